// ---- core/sarc_cfg.svh ----
// Timing counts and code constants for the SAR conversion control block
`ifndef SARC_CFG_SVH
`define SARC_CFG_SVH

// ----------------------------------------------------------------------
// Resolution and codes
// ----------------------------------------------------------------------
`define SARC_NBITS          16
`define SARC_CODE_ZERO      16'h0000
`define SARC_CODE_MID       16'h8000
`define SARC_CODE_FULL      16'hFFFF

// ----------------------------------------------------------------------
// Timing, in ns, with derived cycle counts at 125 MHz
// ----------------------------------------------------------------------
`define SARC_CLK_PERIOD_NS  8
`define SARC_APERTURE_NS    16
`define SARC_APERTURE_CYC   ((`SARC_APERTURE_NS + `SARC_CLK_PERIOD_NS - 1) / `SARC_CLK_PERIOD_NS)
`define SARC_SWITCH_NS      16
`define SARC_SWITCH_CYC     ((`SARC_SWITCH_NS + `SARC_CLK_PERIOD_NS - 1) / `SARC_CLK_PERIOD_NS)
`define SARC_BITCLK_DIV     4

`endif

// ---- core/sarc_pkg.sv ----
// Types shared by the SAR conversion control block
`default_nettype none

package sarc_pkg;

   // -------------------------------------------------------------------
   // Control sequencer states
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      SARC_ACQ,
      SARC_APERTURE,
      SARC_OPEN_GND,
      SARC_TO_GND,
      SARC_SEARCH,
      SARC_DONE
   } sarc_state_t;

   typedef logic [15:0] sarc_code_t;

endpackage

`default_nettype wire

// ---- core/sarc_tick_gen.sv ----
// Internal conversion clock tick generator
`include "sarc_cfg.svh"
`default_nettype none

module sarc_tick_gen
   import sarc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Control
   input  wire logic run,
   output logic      tick
);

   // -------------------------------------------------------------------
   // Divider
   // -------------------------------------------------------------------
   localparam logic [3:0] DIV_LAST = 4'(`SARC_BITCLK_DIV - 1);

   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       tick_d;

   // Restart from zero at each run so step timing is fixed per conversion
   assign tick_d = run && (cnt_q == DIV_LAST);
   assign cnt_d  = (!run || tick_d) ? 4'h0 : cnt_q + 4'h1;

   // Count and tick registers
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 4'h0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end

endmodule

`default_nettype wire

// ---- core/sarc_result_reg.sv ----
// Result holding register, loaded when the conversion finishes
`include "sarc_cfg.svh"
`default_nettype none

module sarc_result_reg
   import sarc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Load side
   input  wire logic       load,
   input  wire sarc_code_t code_in,
   // Read side
   output sarc_code_t      code_out
);

   // -------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------
   // Output is a register so readers see no combinational path
   always_ff @(posedge clk) begin
      if (rst) begin
         code_out <= `SARC_CODE_ZERO;
      end else if (load) begin
         code_out <= code_in;
      end
   end

endmodule

`default_nettype wire

// ---- core/sarc_conversion_control.sv ----
// SAR conversion control: start, sampling switches, bit search and result
`include "sarc_cfg.svh"
`default_nettype none

module sarc_conversion_control
   import sarc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Host side
   input  wire logic convert_start,
   // Analogue front end controls
   input  wire logic comp_hi,
   output logic      hold,
   output logic      pos_sampling_switch,
   output logic      neg_sampling_switch,
   output logic      array_to_gnd,
   output logic [15:0] dac_bits,
   output logic      low_power,
   // Result side
   output logic      busy,
   output logic      result_valid,
   output logic [15:0] result
);

   // -------------------------------------------------------------------
   // State and counters
   // -------------------------------------------------------------------
   localparam logic [3:0] APER_LAST = 4'(`SARC_APERTURE_CYC - 1);
   localparam logic [3:0] SW_LAST   = 4'(`SARC_SWITCH_CYC - 1);

   sarc_state_t state_q;
   sarc_state_t state_d;
   logic [3:0]  wait_q;
   logic [3:0]  wait_d;
   logic [3:0]  bit_q;
   logic [3:0]  bit_d;
   logic [15:0] trial_q;
   logic [15:0] trial_d;
   logic        start_prev_q;
   logic        tick;
   logic        search_run;
   logic        start_edge;
   logic        wait_done_aper;
   logic        wait_done_sw;
   logic        last_bit;
   logic        latch_res;
   logic        in_conv;
   sarc_code_t  final_code;
   sarc_code_t  res_code;
   logic [15:0] try_mask;
   logic [15:0] next_mask;
   logic        nx_acq;
   logic        nx_aper;
   logic        nx_search;
   logic        nx_done;
   logic        hold_d;
   logic        sw_closed_d;
   logic        gnd_d;
   logic        lp_d;
   logic        busy_d;

   // -------------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------------
   // Edge is seen only in acquisition, so later start levels do nothing
   assign start_edge     = convert_start && !start_prev_q && !in_conv;
   assign wait_done_aper = (wait_q == APER_LAST);
   assign wait_done_sw   = (wait_q == SW_LAST);
   assign last_bit       = (bit_q == 4'h0);
   assign search_run     = (state_q == SARC_SEARCH);
   assign latch_res      = (state_q == SARC_DONE);
   assign in_conv        = (state_q != SARC_ACQ);

   // One-hot select of the weight under trial, one entry per bit
   generate
      for (genvar i = 0; i < 16; i++) begin : g_try
         assign try_mask[i] = (bit_q == 4'(i));
      end
   endgenerate

   // Next lower weight is the current select moved down by one place
   assign next_mask      = {1'b0, try_mask[15:1]};

   // Comparator kept or dropped on the tick; final code has no offset
   // so an overranged input keeps every bit and an underranged one none
   assign final_code     = comp_hi ? trial_q : (trial_q & ~try_mask);

   // -------------------------------------------------------------------
   // Internal conversion clock
   // -------------------------------------------------------------------
   // No serial clock participates; the tick alone paces the search
   sarc_tick_gen u_tick (
      .clk  (clk),
      .rst  (rst),
      .run  (search_run),
      .tick (tick)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      wait_d  = wait_q;
      bit_d   = bit_q;
      trial_d = trial_q;
      unique case (state_q)
         SARC_ACQ: begin
            // Idle in low power until a fresh start edge
            if (start_edge) begin
               state_d = SARC_APERTURE;
               wait_d  = 4'h0;
            end
         end
         SARC_APERTURE: begin
            // Input held once the aperture delay has run
            if (wait_done_aper) begin
               state_d = SARC_OPEN_GND;
               wait_d  = 4'h0;
            end else begin
               wait_d  = wait_q + 4'h1;
            end
         end
         SARC_OPEN_GND: begin
            // Sampling switches open first, settle before arrays move
            if (wait_done_sw) begin
               state_d = SARC_TO_GND;
               wait_d  = 4'h0;
            end else begin
               wait_d  = wait_q + 4'h1;
            end
         end
         SARC_TO_GND: begin
            // Arrays off the inputs; search then opens at the MSB
            if (wait_done_sw) begin
               state_d = SARC_SEARCH;
               bit_d   = 4'hF;
               trial_d = `SARC_CODE_MID;
            end else begin
               wait_d  = wait_q + 4'h1;
            end
         end
         SARC_SEARCH: begin
            // One comparator sample per tick, then the next lower bit
            if (tick) begin
               trial_d = final_code;
               if (last_bit) begin
                  state_d = SARC_DONE;
               end else begin
                  bit_d   = bit_q - 4'h1;
                  trial_d = final_code | next_mask;
               end
            end
         end
         SARC_DONE: begin
            // Result latched on leaving; back to acquisition
            state_d = SARC_ACQ;
         end
         default: begin
            // Unused codes fall back to idle
            state_d = SARC_ACQ;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // Sequencer registers
   // -------------------------------------------------------------------
   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= SARC_ACQ;
      end else begin
         state_q <= state_d;
      end
   end

   // Settle counter shared by the aperture and switch phases
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_q <= 4'h0;
      end else begin
         wait_q <= wait_d;
      end
   end

   // Bit index and trial word of the search
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_q   <= 4'hF;
         trial_q <= `SARC_CODE_ZERO;
      end else begin
         bit_q   <= bit_d;
         trial_q <= trial_d;
      end
   end

   // Start level high at reset release is not taken as an edge: a host
   // must lower it first, avoiding a spurious conversion at power up
   always_ff @(posedge clk) begin
      if (rst) begin
         start_prev_q <= 1'b1;
      end else begin
         start_prev_q <= convert_start;
      end
   end

   // -------------------------------------------------------------------
   // Front end next values
   // -------------------------------------------------------------------
   // Decoded from the next state, so each front end flop and busy move on the
   // same edge as the sequencer and lag it by no cycle
   assign nx_acq      = (state_d == SARC_ACQ);
   assign nx_aper     = (state_d == SARC_APERTURE);
   assign nx_search   = (state_d == SARC_SEARCH);
   assign nx_done     = (state_d == SARC_DONE);

   // Switches stay closed through the aperture, so the input is held
   // only once they open; the arrays move to ground two phases (four cycles) later
   assign hold_d      = !nx_acq && !nx_aper;
   assign sw_closed_d = nx_acq || nx_aper;
   assign gnd_d       = nx_search || nx_done;
   assign lp_d        = nx_acq;
   assign busy_d      = !nx_acq;

   // -------------------------------------------------------------------
   // Front end outputs
   // -------------------------------------------------------------------
   // Sampling switches, both sides alike
   always_ff @(posedge clk) begin
      if (rst) begin
         pos_sampling_switch <= 1'b1;
         neg_sampling_switch <= 1'b1;
      end else begin
         pos_sampling_switch <= sw_closed_d;
         neg_sampling_switch <= sw_closed_d;
      end
   end

   // Hold and array grounding
   always_ff @(posedge clk) begin
      if (rst) begin
         hold         <= 1'b0;
         array_to_gnd <= 1'b0;
      end else begin
         hold         <= hold_d;
         array_to_gnd <= gnd_d;
      end
   end

   // Trial word and power state
   always_ff @(posedge clk) begin
      if (rst) begin
         dac_bits  <= `SARC_CODE_ZERO;
         low_power <= 1'b1;
      end else begin
         dac_bits  <= trial_d;
         low_power <= lp_d;
      end
   end

   // -------------------------------------------------------------------
   // Busy and result
   // -------------------------------------------------------------------
   // Code is the plain search word: straight binary, saturating
   assign res_code = trial_q;

   // Loaded in the last busy cycle, same conversion, no pipeline
   sarc_result_reg u_res (
      .clk      (clk),
      .rst      (rst),
      .load     (latch_res),
      .code_in  (res_code),
      .code_out (result)
   );

   // Busy covers start to latch; valid pulses as busy falls
   always_ff @(posedge clk) begin
      if (rst) begin
         busy         <= 1'b0;
         result_valid <= 1'b0;
      end else begin
         busy         <= busy_d;
         result_valid <= latch_res;
      end
   end

endmodule

`default_nettype wire

// ---- tb/sarc_comp_model.sv ----
// Comparator stand-in that judges the held input against the trial word
`default_nettype none
module sarc_comp_model (
   // Clock
   input  wire logic               clk,
   // Analogue side
   input  wire logic signed [17:0] vin,
   input  wire logic               hold,
   input  wire logic [15:0]        dac_bits,
   output logic                    comp_hi
);
   timeunit 1ns;
   timeprecision 1ps;
   logic junk_q = 1'b0;
   // Output churns while nothing is held, so a stray sample is caught
   always @(posedge clk) begin
      junk_q <= ~junk_q;
   end
   // Keep the bit when the input reaches the trial word; clips both ends
   assign comp_hi = hold ? (vin >= $signed({2'b00, dac_bits})) : junk_q;
endmodule
`default_nettype wire

// ---- tb/sarc_conversion_control_assertions.sv ----
// Checker of the conversion control sequencing
`default_nettype none
module sarc_cc_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Watched ports
   input wire logic        convert_start,
   input wire logic        hold,
   input wire logic        pos_sampling_switch,
   input wire logic        neg_sampling_switch,
   input wire logic        array_to_gnd,
   input wire logic [15:0] dac_bits,
   input wire logic        low_power,
   input wire logic        busy,
   input wire logic        result_valid,
   input wire logic [15:0] result
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_start; !busy && $rose(convert_start) |=> busy; endproperty
   a_start: assert property (p_start) else $error("start ignored");
   property p_lat; $rose(busy) |-> ##[60:90] result_valid; endproperty
   a_lat: assert property (p_lat) else $error("no result in time");
   property p_valid; result_valid |-> !busy && $past(busy) && low_power; endproperty
   a_valid: assert property (p_valid) else $error("bad finish");
   property p_order; $fell(pos_sampling_switch) |-> hold && !array_to_gnd ##[1:4] array_to_gnd;
   endproperty
   a_order: assert property (p_order) else $error("switch order");
   property p_pair; pos_sampling_switch == neg_sampling_switch; endproperty
   a_pair: assert property (p_pair) else $error("switch mismatch");
   property p_msb; $rose(array_to_gnd) |-> dac_bits == 16'h8000; endproperty
   a_msb: assert property (p_msb) else $error("first trial not msb");
   property p_lp; $rose(busy) |-> !low_power; endproperty
   a_lp: assert property (p_lp) else $error("still in low power");
   property p_keep; !result_valid && !$past(rst) |-> $stable(result); endproperty
   a_keep: assert property (p_keep) else $error("result moved");
   property p_run; busy && $fell(convert_start) |-> ##[1:90] result_valid; endproperty
   a_run: assert property (p_run) else $error("conversion cut short");
endmodule
bind sarc_conversion_control sarc_cc_chk i_sarc_cc_chk (
   .clk(clk), .rst(rst), .convert_start(convert_start), .hold(hold),
   .pos_sampling_switch(pos_sampling_switch), .neg_sampling_switch(neg_sampling_switch),
   .array_to_gnd(array_to_gnd), .dac_bits(dac_bits), .low_power(low_power),
   .busy(busy), .result_valid(result_valid), .result(result));
`default_nettype wire

// ---- tb/sarc_conversion_control_tb.sv ----
// Self-checking bench for the conversion control block
`default_nettype none
module sarc_conversion_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sarc_pkg::*;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t got %h want %h", $time, g, e); end end
   logic               clk;
   logic               rst;
   logic               convert_start;
   logic               comp_hi;
   logic               hold;
   logic               pos_sw;
   logic               neg_sw;
   logic               array_to_gnd;
   logic [15:0]        dac_bits;
   logic               low_power;
   logic               busy;
   logic               result_valid;
   logic [15:0]        result;
   logic signed [17:0] vin;
   int                 mismatches = 0;
   int                 num_checks = 0;
   sarc_conversion_control i_sarc_conversion_control (.clk(clk), .rst(rst),
      .convert_start(convert_start), .comp_hi(comp_hi), .hold(hold),
      .pos_sampling_switch(pos_sw), .neg_sampling_switch(neg_sw),
      .array_to_gnd(array_to_gnd), .dac_bits(dac_bits), .low_power(low_power),
      .busy(busy), .result_valid(result_valid), .result(result));
   sarc_comp_model i_sarc_comp_model (.clk(clk), .vin(vin), .hold(hold),
      .dac_bits(dac_bits), .comp_hi(comp_hi));
   // ------------------------------------------------------------------
   // Drivers and scenarios
   // ------------------------------------------------------------------
   // Start needs a low sample first, else no edge is seen
   task automatic start_conv(input logic signed [17:0] v);
      @(posedge clk);
      vin <= v;
      convert_start <= 1'b0;
      @(posedge clk);
      convert_start <= 1'b1;
   endtask
   task automatic wait_done(output int n);
      n = 0;
      while (result_valid !== 1'b1 && n < 150) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic conv(input logic signed [17:0] v, input sarc_code_t want);
      int n;
      start_conv(v);
      repeat (4) if (busy !== 1'b1) @(negedge clk);
      `CHK(busy, 1'b1)
      `CHK(low_power, 1'b0)
      wait_done(n);
      `CHK(n > 55 && n < 90, 1'b1)
      `CHK(result, want)
      `CHK(busy, 1'b0)
      `CHK(low_power & pos_sw, 1'b1)
      @(negedge clk);
      `CHK(result, want)
   endtask
   task automatic t_codes();
      conv(18'sd0, 16'h0000);
      conv(18'sd32768, 16'h8000);
      conv(18'sd32769, 16'h8001);
      conv(18'sd32767, 16'h7FFF);
      conv(18'sd1, 16'h0001);
      conv(18'sd65535, 16'hFFFF);
   endtask
   task automatic t_range();
      conv(18'sd70000, 16'hFFFF);
      conv(-18'sd100, 16'h0000);
   endtask
   // Start toggled mid-run must neither stop nor queue a conversion
   task automatic t_ignore();
      int n;
      start_conv(18'sd4660);
      repeat (10) @(posedge clk);
      convert_start <= 1'b0;
      repeat (10) @(posedge clk);
      convert_start <= 1'b1;
      wait_done(n);
      `CHK(result, 16'h1234)
      repeat (100) begin
         @(negedge clk);
         if (result_valid === 1'b1) n = -1;
      end
      `CHK(n >= 0, 1'b1)
   endtask
   task automatic t_reset();
      start_conv(18'sd17185);
      repeat (30) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK({busy, result}, 17'h0_0000)
      `CHK(low_power, 1'b1)
      conv(18'sd255, 16'h00FF);
   endtask
   task automatic end_sim();
      if (mismatches == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Watchdog well beyond a dozen conversions
   initial begin
      #160000;
      mismatches++;
      end_sim();
   end
   initial begin
      rst = 1'b1;
      convert_start = 1'b0;
      vin = '0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_codes();
      t_range();
      t_ignore();
      t_reset();
      end_sim();
   end
endmodule
`default_nettype wire
